// >>> swu_consts.svh
// constants of the single-wire uart read link
// Operation
// - request is sync, address, register, crc bytes
// - reply uses the request's baud rate
// - reply waits a multiple of eight bits
// - reply: sync, 0xFF, register, data, crc
// - drive four more bits, then release line
// - all-ones address is only for replies
// - crc8 x^8+x^2+x+1 from zero, lsb first
// - shift left, xor 0x07 on mismatch
// - crc is the last byte of datagram
// - act only on good crc and own address
// - sync nibble assumed correct, still in crc
// - count good write datagrams, not reads
// - re-measure bit time every datagram sync
// - enable driver only for the reply
// - line level is not inverted
// - master frames 8N1, ten bit times
// - master releases buffer after last stop bit
// - master discards its own echo
// - master raises node select before access
// - start low, stop high, sync edges timed
// - gap over 63 bits resets, 12 idle needed
// - delay setting pairs map to odd multiples
// - register byte top bit marks a write
`ifndef SWU_CONSTS_SVH
`define SWU_CONSTS_SVH
`define SWU_CLK_HZ          20000000
`define SWU_MIN_BAUD        9000
`define SWU_RESET_BIT_TIME  16'(`SWU_CLK_HZ / `SWU_MIN_BAUD)
`define SWU_MIN_BIT_TIME    16'd16
`define SWU_SYNC_BYTE       8'h05
`define SWU_SYNC_KNOWN      8'hA0
`define SWU_SYNC_DATA_IDX   4'h4
`define SWU_MASTER_ADDR     8'hFF
`define SWU_WRITE_BIT       7
`define SWU_CRC_POLY        8'h07
`define SWU_CRC_INIT        8'h00
`define SWU_REQ_LAST        3'h3
`define SWU_WR_LAST         3'h7
`define SWU_REPLY_BYTES     4'h8
`define SWU_STOP_IDX        4'h9
`define SWU_HOLD_BITS       8'h04
`define SWU_GAP_MAX_BITS    8'h3F
`define SWU_RECOVER_BITS    8'h0C
`define SWU_DELAY_UNIT_BITS 8'h08
`define SWU_DEFAULT_DELAY   4'h0
`define SWU_FIFO_WIDTH      8
`define SWU_FIFO_DEPTH      4
`define SWU_HOST_BAUD       500000
`define SWU_HOST_BIT_TIME   16'(`SWU_CLK_HZ / `SWU_HOST_BAUD)
`define SWU_HOST_TIMEOUT    32'h00002710
`endif

// >>> swu_pkg.sv
// types and crc helper shared by both ends
package swu_pkg;
	`include "swu_consts.svh"

	typedef enum logic [3:0] {N_IDLE, N_MEASURE, N_RX_BIT, N_RX_GAP, N_RECOVER,
		N_DELAY, N_TX_LOAD, N_TX_BIT, N_TX_HOLD} swu_node_state_e;
	typedef enum logic [2:0] {H_IDLE, H_LOAD, H_BIT, H_WAIT, H_RX_BIT} swu_host_state_e;

	// one byte through the crc, lsb first
	function automatic logic [7:0] swu_crc_byte(input logic [7:0] crc_in,
		input logic [7:0] data);
		logic [7:0] c;
		c = crc_in;
		for (int j = 0; j < 8; j++) begin
			if (c[7] ^ data[j]) begin
				c = {c[6:0], 1'b0} ^ `SWU_CRC_POLY;
			end else begin
				c = {c[6:0], 1'b0};
			end
		end
		return c;
	endfunction : swu_crc_byte
endpackage : swu_pkg

// >>> swu_if.sv
// shared single wire with pull-up and analog select switch
`timescale 1ns/1ps
interface swu_if;
	logic node_out;
	logic node_oe;
	logic host_out;
	logic host_oe;
	logic sel;
	wire  line;
	wire  node_line;

	// pulled high when nobody drives; node is cut off while deselected
	assign line      = (~(node_oe & sel) | node_out) & (~host_oe | host_out);
	assign node_line = sel ? line : 1'b1;

	modport node (input node_line, output node_out, output node_oe);
	modport host (input line, output host_out, output host_oe, output sel);
endinterface : swu_if

// >>> swu_node.sv
// node end: request receiver, reply fifo and reply transmitter
`timescale 1ns/1ps
`include "swu_consts.svh"
module swu_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input  wire logic             i_clock,
	input  wire logic             i_sys_rst,
	input  wire logic             i_wr_valid,
	output logic                  o_wr_ready,
	input  wire logic [WIDTH-1:0] i_wr_data,
	output logic                  o_rd_valid,
	input  wire logic             i_rd_ready,
	output logic      [WIDTH-1:0] o_rd_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wp_q;
	logic [AW-1:0]    rp_q;
	logic [AW:0]      cnt_q;
	wire              push = i_wr_valid & o_wr_ready;
	wire              pop  = o_rd_valid & i_rd_ready;

	assign o_wr_ready = (cnt_q != (AW+1)'(DEPTH));
	assign o_rd_valid = (cnt_q != '0);
	assign o_rd_data  = mem_q[rp_q];

	// pointers wrap at a power-of-two depth
	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			wp_q  <= '0;
			rp_q  <= '0;
			cnt_q <= '0;
		end else begin
			wp_q  <= push ? wp_q + 1'b1 : wp_q;
			rp_q  <= pop ? rp_q + 1'b1 : rp_q;
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	// storage needs no reset
	always_ff @(posedge i_clock) begin
		if (push) begin
			mem_q[wp_q] <= i_wr_data;
		end
	end
endmodule : swu_fifo

module swu_node
	import swu_pkg::*;
(
	swu_if.node              bus,
	input  wire logic        i_clock,
	input  wire logic        i_sys_rst,
	input  wire logic [7:0]  i_node_address_value,
	input  wire logic [3:0]  i_reply_delay_setting,
	input  wire logic [31:0] i_reg_rd_data,
	output logic             o_reg_rd_req,
	output logic [6:0]       o_reg_addr,
	output logic             o_wr_valid,
	output logic [31:0]      o_wr_data,
	output logic [7:0]       o_write_datagram_counter,
	output logic             o_crc_error
);
	swu_node_state_e st_q;
	logic [15:0] bit_time_q;
	logic [17:0] meas_q;
	logic        edge_seen_q;
	logic [15:0] ph_q;
	logic [7:0]  bits_q;
	logic [3:0]  bidx_q;
	logic [7:0]  sh_q;
	logic [7:0]  crc_q;
	logic [2:0]  bc_q;
	logic        is_wr_q;
	logic        addr_ok_q;
	logic [31:0] data_q;
	logic        line_q;
	logic [7:0]  tx_q;
	logic        out_q;
	logic        oe_q;
	logic [3:0]  gen_idx_q;
	logic [7:0]  tcrc_q;
	logic [31:0] rd_data_q;

	// line sampling and decode of the receiver
	wire        line      = bus.node_line;
	wire        fall      = line_q & ~line;
	wire        ph_zero   = (ph_q == 16'h0000);
	wire [15:0] ph_bit    = bit_time_q - 16'h0001;
	wire [15:0] meas_bit  = meas_q[17:2]; // sync spans four bit times
	wire [7:0]  crc_next  = swu_crc_byte(crc_q, sh_q);
	wire        last_byte = (bc_q == `SWU_WR_LAST) || (bc_q == `SWU_REQ_LAST && !is_wr_q);
	wire [7:0]  delay_tgt = 8'({i_reply_delay_setting[3:1], 1'b1}) * `SWU_DELAY_UNIT_BITS;
	wire        own_addr  = (sh_q == i_node_address_value)
		&& (i_node_address_value != `SWU_MASTER_ADDR);

	// reply byte generator feeding the fifo
	wire [1:0]  dsel     = 2'(3'h6 - gen_idx_q[2:0]);
	wire [7:0]  data_b   = rd_data_q[{dsel, 3'b000} +: 8];
	wire [7:0]  gen_byte = (gen_idx_q == 4'h0) ? `SWU_SYNC_BYTE :
		(gen_idx_q == 4'h1) ? `SWU_MASTER_ADDR :
		(gen_idx_q == 4'h2) ? {1'b0, o_reg_addr} :
		(gen_idx_q == 4'h7) ? tcrc_q : data_b;
	wire        gen_done = (gen_idx_q == `SWU_REPLY_BYTES);
	wire        gen_valid = !gen_done;
	wire        gen_ready;
	wire        f_valid;
	wire [7:0]  f_data;
	wire        f_ready  = (st_q == N_TX_LOAD);

	swu_fifo #(.WIDTH(`SWU_FIFO_WIDTH), .DEPTH(`SWU_FIFO_DEPTH)) u_fifo (
		.i_clock    (i_clock),
		.i_sys_rst  (i_sys_rst),
		.i_wr_valid (gen_valid),
		.o_wr_ready (gen_ready),
		.i_wr_data  (gen_byte),
		.o_rd_valid (f_valid),
		.i_rd_ready (f_ready),
		.o_rd_data  (f_data)
	);

	// generator stalls on a full fifo; crc covers bytes before the last
	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			gen_idx_q <= `SWU_REPLY_BYTES;
			tcrc_q    <= `SWU_CRC_INIT;
			rd_data_q <= '0;
		end else if (o_reg_rd_req) begin
			gen_idx_q <= 4'h0;
			tcrc_q    <= `SWU_CRC_INIT;
		end else begin
			rd_data_q <= (gen_idx_q == 4'h0) ? i_reg_rd_data : rd_data_q;
			if (gen_valid && gen_ready) begin
				gen_idx_q <= gen_idx_q + 4'h1;
				tcrc_q    <= swu_crc_byte(tcrc_q, gen_byte);
			end
		end
	end

	// main sequencer: measure, receive, wait, reply, release
	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			st_q <= N_IDLE;
			bit_time_q <= `SWU_RESET_BIT_TIME;
			meas_q <= '0;
			edge_seen_q <= 1'b0;
			ph_q <= '0;
			bits_q <= '0;
			bidx_q <= '0;
			sh_q <= '0;
			crc_q <= `SWU_CRC_INIT;
			bc_q <= '0;
			is_wr_q <= 1'b0;
			addr_ok_q <= 1'b0;
			data_q <= '0;
			line_q <= 1'b1;
			tx_q <= '0;
			out_q <= 1'b1;
			oe_q <= 1'b0;
			o_reg_rd_req <= 1'b0;
			o_reg_addr <= '0;
			o_wr_valid <= 1'b0;
			o_wr_data <= '0;
			o_write_datagram_counter <= '0;
			o_crc_error <= 1'b0;
		end else begin
			line_q <= line;
			o_reg_rd_req <= 1'b0;
			o_wr_valid <= 1'b0;
			o_crc_error <= 1'b0;
			ph_q <= ph_zero ? ph_bit : ph_q - 16'h0001;
			bits_q <= ph_zero ? bits_q + 8'h01 : bits_q;
			unique case (st_q)
				N_IDLE: begin
					if (fall) begin
						st_q <= N_MEASURE;
						meas_q <= 18'h00001;
						edge_seen_q <= 1'b0;
					end
				end
				N_MEASURE: begin
					meas_q <= meas_q + 18'h00001;
					if (meas_q[17]) begin
						st_q <= N_RECOVER;
						bits_q <= '0;
					end else if (fall && !edge_seen_q) begin
						edge_seen_q <= 1'b1;
					end else if (fall && meas_bit < `SWU_MIN_BIT_TIME) begin
						st_q <= N_RECOVER;
						bits_q <= '0;
					end else if (fall) begin
						bit_time_q <= meas_bit;
						ph_q <= {1'b0, meas_q[17:3]};
						bits_q <= 8'(`SWU_SYNC_DATA_IDX);
						bidx_q <= `SWU_SYNC_DATA_IDX;
						sh_q <= `SWU_SYNC_KNOWN;
						crc_q <= `SWU_CRC_INIT;
						bc_q <= '0;
						st_q <= N_RX_BIT;
					end
				end
				N_RX_BIT: begin
					if (ph_zero) begin
						bidx_q <= bidx_q + 4'h1;
						if (bidx_q == 4'h0 && line) begin
							st_q <= N_RECOVER;
							bits_q <= '0;
						end else if (bidx_q != 4'h0 && bidx_q != `SWU_STOP_IDX) begin
							sh_q <= {line, sh_q[7:1]};
						end else if (bidx_q == `SWU_STOP_IDX && !line) begin
							st_q <= N_RECOVER;
							bits_q <= '0;
						end else if (bidx_q == `SWU_STOP_IDX && last_byte) begin
							if (crc_q != sh_q) begin
								o_crc_error <= 1'b1;
								st_q <= N_RECOVER;
								bits_q <= '0;
							end else if (!addr_ok_q) begin
								st_q <= N_IDLE;
							end else if (is_wr_q) begin
								o_wr_valid <= 1'b1;
								o_wr_data <= data_q;
								o_write_datagram_counter <= o_write_datagram_counter + 8'h01;
								st_q <= N_IDLE;
							end else begin
								o_reg_rd_req <= 1'b1;
								st_q <= N_DELAY;
								bits_q <= '0;
								ph_q <= ph_bit;
							end
						end else if (bidx_q == `SWU_STOP_IDX) begin
							crc_q <= crc_next;
							bc_q <= bc_q + 3'h1;
							addr_ok_q <= (bc_q == 3'h1) ? own_addr : addr_ok_q;
							if (bc_q == 3'h2) begin
								o_reg_addr <= sh_q[6:0];
								is_wr_q <= sh_q[`SWU_WRITE_BIT];
							end
							data_q <= (bc_q > 3'h2) ? {data_q[23:0], sh_q} : data_q;
							st_q <= N_RX_GAP;
						end
					end
				end
				N_RX_GAP: begin
					if (fall) begin
						ph_q <= {1'b0, bit_time_q[15:1]};
						bits_q <= '0;
						bidx_q <= '0;
						st_q <= N_RX_BIT;
					end else if (bits_q > `SWU_GAP_MAX_BITS) begin
						st_q <= N_RECOVER;
						bits_q <= '0;
					end
				end
				N_RECOVER: begin
					if (!line) begin
						bits_q <= '0;
						ph_q <= ph_bit;
					end else if (bits_q == `SWU_RECOVER_BITS) begin
						st_q <= N_IDLE;
					end
				end
				N_DELAY: begin
					if (bits_q == delay_tgt) begin
						st_q <= N_TX_LOAD;
					end
				end
				N_TX_LOAD: begin
					oe_q <= 1'b1;
					if (f_valid) begin
						tx_q <= f_data;
						out_q <= 1'b0;
						ph_q <= ph_bit;
						bidx_q <= '0;
						st_q <= N_TX_BIT;
					end
				end
				N_TX_BIT: begin
					if (ph_zero && bidx_q < 4'h8) begin
						out_q <= tx_q[0];
						tx_q <= {1'b0, tx_q[7:1]};
						bidx_q <= bidx_q + 4'h1;
					end else if (ph_zero && bidx_q == 4'h8) begin
						out_q <= 1'b1;
						bidx_q <= `SWU_STOP_IDX;
					end else if (ph_zero) begin
						st_q <= (gen_done && !f_valid) ? N_TX_HOLD : N_TX_LOAD;
						bits_q <= '0;
					end
				end
				N_TX_HOLD: begin
					if (bits_q == `SWU_HOLD_BITS) begin
						oe_q <= 1'b0;
						st_q <= N_IDLE;
					end
				end
			endcase
		end
	end

	assign bus.node_out = out_q;
	assign bus.node_oe  = oe_q;
endmodule : swu_node

// >>> swu_master.sv
// master end: sends requests, collects replies
`timescale 1ns/1ps
`include "swu_consts.svh"
module swu_master
	import swu_pkg::*;
#(
	parameter logic [31:0] REPLY_TIMEOUT = `SWU_HOST_TIMEOUT
) (
	swu_if.host              bus,
	input  wire logic        i_clock,
	input  wire logic        i_sys_rst,
	input  wire logic        i_start,
	input  wire logic        i_write,
	input  wire logic [7:0]  i_node_address_value,
	input  wire logic [6:0]  i_reg_addr,
	input  wire logic [31:0] i_wr_data,
	output logic             o_busy,
	output logic             o_rd_valid,
	output logic [31:0]      o_rd_data,
	output logic             o_rd_error
);
	swu_host_state_e st_q;
	logic [15:0] ph_q;
	logic [3:0]  bidx_q;
	logic [2:0]  idx_q;
	logic [7:0]  sh_q;
	logic [7:0]  crc_q;
	logic        wr_q;
	logic [7:0]  node_q;
	logic [6:0]  reg_q;
	logic [31:0] data_q;
	logic [31:0] to_q;
	logic        err_q;
	logic        line_q;
	logic        out_q;
	logic        oe_q;
	logic        sel_q;

	// outgoing byte selection and receive decode
	wire       fall     = line_q & ~bus.line;
	wire       ph_zero  = (ph_q == 16'h0000);
	wire [2:0] last_idx = wr_q ? `SWU_WR_LAST : `SWU_REQ_LAST;
	wire [1:0] dsel     = 2'(3'h6 - idx_q);
	wire [7:0] cur_byte = (idx_q == last_idx) ? crc_q :
		(idx_q == 3'h0) ? `SWU_SYNC_BYTE :
		(idx_q == 3'h1) ? node_q :
		(idx_q == 3'h2) ? {wr_q, reg_q} : data_q[{dsel, 3'b000} +: 8];
	wire       hdr_bad  = ((idx_q == 3'h1) && (sh_q != `SWU_MASTER_ADDR))
		|| ((idx_q == 3'h2) && (sh_q != {1'b0, reg_q}));

	// one sequencer for send, turnaround and reply receive
	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			st_q <= H_IDLE;
			ph_q <= '0;
			bidx_q <= '0;
			idx_q <= '0;
			sh_q <= '0;
			crc_q <= `SWU_CRC_INIT;
			wr_q <= 1'b0;
			node_q <= '0;
			reg_q <= '0;
			data_q <= '0;
			to_q <= '0;
			err_q <= 1'b0;
			line_q <= 1'b1;
			out_q <= 1'b1;
			oe_q <= 1'b0;
			sel_q <= 1'b0;
			o_busy <= 1'b0;
			o_rd_valid <= 1'b0;
			o_rd_data <= '0;
			o_rd_error <= 1'b0;
		end else begin
			line_q <= bus.line;
			o_rd_valid <= 1'b0;
			o_rd_error <= 1'b0;
			ph_q <= ph_zero ? `SWU_HOST_BIT_TIME - 16'h0001 : ph_q - 16'h0001;
			unique case (st_q)
				H_IDLE: begin
					if (i_start) begin
						sel_q <= 1'b1;
						o_busy <= 1'b1;
						wr_q <= i_write;
						node_q <= i_node_address_value;
						reg_q <= i_reg_addr;
						data_q <= i_wr_data;
						idx_q <= '0;
						crc_q <= `SWU_CRC_INIT;
						st_q <= H_LOAD;
					end
				end
				H_LOAD: begin
					oe_q <= 1'b1;
					out_q <= 1'b0;
					sh_q <= cur_byte;
					crc_q <= swu_crc_byte(crc_q, cur_byte);
					ph_q <= `SWU_HOST_BIT_TIME - 16'h0001;
					bidx_q <= '0;
					st_q <= H_BIT;
				end
				H_BIT: begin
					if (ph_zero && bidx_q < 4'h8) begin
						out_q <= sh_q[0];
						sh_q <= {1'b0, sh_q[7:1]};
						bidx_q <= bidx_q + 4'h1;
					end else if (ph_zero && bidx_q == 4'h8) begin
						out_q <= 1'b1;
						bidx_q <= `SWU_STOP_IDX;
					end else if (ph_zero && idx_q != last_idx) begin
						idx_q <= idx_q + 3'h1;
						st_q <= H_LOAD;
					end else if (ph_zero) begin
						oe_q <= 1'b0;
						idx_q <= '0;
						crc_q <= `SWU_CRC_INIT;
						err_q <= 1'b0;
						to_q <= '0;
						sel_q <= !wr_q;
						o_busy <= !wr_q;
						st_q <= wr_q ? H_IDLE : H_WAIT;
					end
				end
				H_WAIT: begin
					to_q <= to_q + 32'h00000001;
					if (fall) begin
						ph_q <= `SWU_HOST_BIT_TIME >> 1;
						bidx_q <= '0;
						st_q <= H_RX_BIT;
					end else if (to_q == REPLY_TIMEOUT) begin
						o_rd_error <= 1'b1;
						sel_q <= 1'b0;
						o_busy <= 1'b0;
						st_q <= H_IDLE;
					end
				end
				H_RX_BIT: begin
					if (ph_zero && bidx_q != `SWU_STOP_IDX) begin
						sh_q <= (bidx_q == 4'h0) ? sh_q : {bus.line, sh_q[7:1]};
						err_q <= err_q | ((bidx_q == 4'h0) & bus.line);
						bidx_q <= bidx_q + 4'h1;
					end else if (ph_zero && idx_q == 3'h7) begin
						o_rd_valid <= !err_q && bus.line && (crc_q == sh_q);
						o_rd_error <= err_q || !bus.line || (crc_q != sh_q);
						sel_q <= 1'b0;
						o_busy <= 1'b0;
						st_q <= H_IDLE;
					end else if (ph_zero) begin
						crc_q <= swu_crc_byte(crc_q, sh_q);
						err_q <= err_q | hdr_bad | !bus.line;
						o_rd_data <= (idx_q > 3'h2) ? {o_rd_data[23:0], sh_q} : o_rd_data;
						idx_q <= idx_q + 3'h1;
						to_q <= '0;
						st_q <= H_WAIT;
					end
				end
			endcase
		end
	end

	assign bus.host_out = out_q;
	assign bus.host_oe  = oe_q;
	assign bus.sel      = sel_q;
endmodule : swu_master

// >>> swu_monitor.sv
// assertions on the shared wire between the master end and the node end
`timescale 1ns/1ps
module swu_monitor #(
	parameter int BIT = 40
) (
	input  wire logic i_clock,
	input  wire logic i_sys_rst,
	input  wire logic node_out,
	input  wire logic node_oe,
	input  wire logic host_oe,
	input  wire logic sel
);
	logic [15:0] hi_q, lo_q, gap_q, en_q, hi_d, lo_d, gap_d, en_d;

	default clocking @(posedge i_clock); endclocking
	default disable iff (i_sys_rst);

	// run lengths of driven levels, and silence since the master let go
	assign hi_d  = (node_oe & node_out) ? hi_q + 16'h0001 : 16'h0000;
	assign lo_d  = (node_oe & ~node_out) ? lo_q + 16'h0001 : 16'h0000;
	assign gap_d = host_oe ? 16'h0000 : gap_q + 16'h0001;
	assign en_d  = node_oe ? en_q + 16'h0001 : 16'h0000;
	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			hi_q  <= 16'h0000;
			lo_q  <= 16'h0000;
			gap_q <= 16'h0000;
			en_q  <= 16'h0000;
		end else begin
			hi_q  <= hi_d;
			lo_q  <= lo_d;
			gap_q <= gap_d;
			en_q  <= en_d;
		end
	end

	// the node only drives into a released wire, selected when it starts; the master only drives while selected
	property p_no_clash;
		node_oe |-> !host_oe;
	endproperty
	a_no_clash: assert property (p_no_clash) else $error("node and master drive together");
	property p_rise_sel;
		$rose(node_oe) |-> sel;
	endproperty
	a_rise_sel: assert property (p_rise_sel) else $error("reply into deselected wire");
	property p_host_sel;
		host_oe |-> sel;
	endproperty
	a_host_sel: assert property (p_host_sel) else $error("master drives without select");

	// turnaround silence lies between the shortest and longest delay setting
	property p_delay_min;
		$rose(node_oe) |-> gap_q >= 16'(7 * BIT);
	endproperty
	a_delay_min: assert property (p_delay_min) else $error("reply came too early");
	property p_delay_max;
		$rose(node_oe) |-> gap_q <= 16'(122 * BIT);
	endproperty
	a_delay_max: assert property (p_delay_max) else $error("reply came too late");

	// framing of the reply: low start bit first, no low run beyond nine bits
	property p_start_low;
		$rose(node_oe) |-> ##[0:2] (!node_out) [*8];
	endproperty
	a_start_low: assert property (p_start_low) else $error("reply lacks start bit");
	property p_low_run;
		lo_q <= 16'(9 * BIT + 2);
	endproperty
	a_low_run: assert property (p_low_run) else $error("missing stop bit");

	// after the last stop bit the wire is held high four bit times, then freed
	property p_hold_min;
		$fell(node_oe) |-> hi_q >= 16'(4 * BIT);
	endproperty
	a_hold_min: assert property (p_hold_min) else $error("driver freed too soon");
	// high run may start at a data bit, so the upper bound uses driver-on time:
	// eight frames of ten bits plus four hold bits, a few load cycles of slack
	property p_hold_max;
		$fell(node_oe) |-> en_q <= 16'(85 * BIT);
	endproperty
	a_hold_max: assert property (p_hold_max) else $error("driver freed too late");
endmodule : swu_monitor

// >>> single_wire_uart_read_crc_tb_top.sv
// bench: master and node on one wire, a hand-driven sender on a second wire
`timescale 1ns/1ps
module single_wire_uart_read_crc_tb_top;
	localparam int B2 = 25;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        start = 1'b0;
	logic        wr = 1'b0;
	logic        oe_q = 1'b0;
	logic        oe2_q = 1'b0;
	logic [7:0]  n_addr = 8'h00;
	logic [7:0]  m_addr = 8'h00;
	logic [7:0]  n_addr2 = 8'hFF;
	logic [7:0]  rnd = 8'h46;
	logic [6:0]  m_reg = 7'h00;
	logic [3:0]  dly = 4'h0;
	logic [31:0] m_wd = 32'h0, rd1 = 32'h0, rd2 = 32'h0, m_rd, wd;
	logic [31:0] mem [128];
	logic [32:0] exp_r;
	logic [6:0]  ra1, ra2;
	logic [7:0]  cnt;
	logic        busy, rv, re, wv, req2, cerr2;
	int          fail_count = 0, comparisons = 0, wr_count = 0, rises = 0;
	int          gap = 0, tgt = 0, n_err2 = 0, n_req2 = 0, n_oe2 = 0;
	logic [32:0] rq [$];
	logic [31:0] wq [$];
	logic [7:0]  q [$], r [$];

	swu_if bus_if ();
	swu_if bus2_if ();
	swu_node swu_node_inst (.bus(bus_if.node), .i_clock(clk), .i_sys_rst(rst),
		.i_node_address_value(n_addr), .i_reply_delay_setting(dly), .i_reg_rd_data(rd1),
		.o_reg_rd_req(), .o_reg_addr(ra1), .o_wr_valid(wv), .o_wr_data(wd),
		.o_write_datagram_counter(cnt), .o_crc_error());
	swu_node swu_node_inst_b (.bus(bus2_if.node), .i_clock(clk), .i_sys_rst(rst),
		.i_node_address_value(n_addr2), .i_reply_delay_setting(4'h0), .i_reg_rd_data(rd2),
		.o_reg_rd_req(req2), .o_reg_addr(ra2), .o_wr_valid(), .o_wr_data(),
		.o_write_datagram_counter(), .o_crc_error(cerr2));
	swu_master swu_master_inst (.bus(bus_if.host), .i_clock(clk), .i_sys_rst(rst),
		.i_start(start), .i_write(wr), .i_node_address_value(m_addr), .i_reg_addr(m_reg),
		.i_wr_data(m_wd), .o_busy(busy), .o_rd_valid(rv), .o_rd_data(m_rd), .o_rd_error(re));
	swu_monitor #(.BIT(40)) swu_monitor_inst (.i_clock(clk), .i_sys_rst(rst),
		.node_out(bus_if.node_out), .node_oe(bus_if.node_oe), .host_oe(bus_if.host_oe),
		.sel(bus_if.sel));

	// 20 MHz clock; register contents follow the fetched address at falling edges
	always #25 clk = ~clk;
	always @(negedge clk) begin
		rd1 <= mem[ra1];
		rd2 <= mem[ra2];
	end

	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr

	// bit-serial check value, independent of the design's helper
	function automatic logic [7:0] crc8(input logic [7:0] d [$]);
		logic [7:0] c;
		c = 8'h00;
		foreach (d[i]) begin
			for (int j = 0; j < 8; j++) begin
				c = (c[7] ^ d[i][j]) ? ({c[6:0], 1'b0} ^ 8'h07) : {c[6:0], 1'b0};
			end
		end
		return c;
	endfunction : crc8

	task automatic check(input logic ok, input string what);
		comparisons++;
		if (ok !== 1'b1) begin
			fail_count++;
			$display("ERROR %0t %s", $time, what);
		end
	endtask : check

	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : stop_test

	// one access by the master end; the expected outcome is noted first
	task automatic access(input logic w, input logic [7:0] na, input logic [3:0] d);
		int t;
		rnd = lfsr(rnd);
		m_reg = rnd[6:0];
		rnd = lfsr(rnd);
		m_wd = {rnd, ~rnd, 8'h5A, rnd ^ 8'h3C};
		dly = d;
		wr = w;
		m_addr = na;
		tgt = int'({d[3:1], 1'b1}) * 320;
		if (w) wq.push_back(m_wd);
		else rq.push_back({na != n_addr, mem[m_reg]});
		rises = 0;
		start = 1'b1;
		@(negedge clk);
		start = 1'b0;
		t = 0;
		do begin
			@(negedge clk);
			t++;
		end while (busy !== 1'b0 && t < 20000);
		check(t < 20000, "access finished in time");
		// covers the node's hold time plus twelve idle bits before the next request
		repeat (640) @(negedge clk);
		check(rises == int'(!w && na == n_addr), "driver enable count");
	endtask : access

	// hand-driven sender on the second wire, 8N1 frames, no echo handling needed
	task automatic send2();
		logic [9:0] f;
		bus2_if.sel = 1'b1;
		bus2_if.host_oe = 1'b1;
		foreach (q[i]) begin
			f = {1'b1, q[i], 1'b0};
			for (int b = 0; b < 10; b++) begin
				bus2_if.host_out = f[b];
				repeat (B2) @(negedge clk);
			end
		end
		bus2_if.host_oe = 1'b0;
	endtask : send2

	// receiver sampling mid-bit at the rate the sender used
	task automatic recv2();
		logic [7:0] b;
		int t;
		r = {};
		for (int n = 0; n < 8; n++) begin
			t = 0;
			while (bus2_if.line !== 1'b0 && t < 8000) begin
				@(negedge clk);
				t++;
			end
			check(t < 8000, "reply byte started");
			repeat (B2 / 2) @(negedge clk);
			for (int k = 0; k < 8; k++) begin
				repeat (B2) @(negedge clk);
				b[k] = bus2_if.line;
			end
			repeat (B2) @(negedge clk);
			check(bus2_if.line === 1'b1, "stop bit");
			r.push_back(b);
		end
	endtask : recv2

	// result watcher: each result is matched against the oldest note;
	// looks at falling edges so every registered output has settled
	always @(negedge clk) begin
		gap = (bus_if.host_oe === 1'b1) ? 0 : gap + 1;
		if (bus_if.node_oe === 1'b1 && oe_q !== 1'b1) begin
			rises++;
			check(gap >= tgt - 40 && gap <= tgt + 80, "reply delay");
		end
		oe_q = bus_if.node_oe;
		if (bus2_if.node_oe === 1'b1 && oe2_q !== 1'b1) n_oe2++;
		oe2_q = bus2_if.node_oe;
		if (cerr2 === 1'b1) n_err2++;
		if (req2 === 1'b1) n_req2++;
		if (rv === 1'b1 || re === 1'b1) begin
			exp_r = rq.pop_front();
			check(re === exp_r[32], "read status");
			if (exp_r[32] === 1'b0) check(m_rd === exp_r[31:0], "read data");
			check(cnt === 8'(wr_count), "count after read");
		end
		if (wv === 1'b1) begin
			wr_count++;
			check(wd === wq.pop_front(), "write data");
			check(cnt === 8'(wr_count), "count after write");
		end
	end

	// main sequence
	initial begin
		bus2_if.sel = 1'b0;
		bus2_if.host_oe = 1'b0;
		bus2_if.host_out = 1'b1;
		foreach (mem[i]) begin
			rnd = lfsr(rnd);
			mem[i] = {rnd, ~rnd, 8'(i), rnd ^ 8'hA5};
		end
		repeat (5) @(negedge clk);
		rst = 1'b0;
		access(1'b1, n_addr, 4'h0);
		access(1'b1, n_addr, 4'h0);
		$display("test writes done");
		for (int s = 0; s < 16; s += 3) access(1'b0, n_addr, 4'(s));
		$display("test reads done");
		access(1'b0, 8'h01, 4'h0);
		$display("test wrong node done");
		// second wire: corrupted check byte, reserved address, then a good read;
		// node b first holds the reserved address itself and must still ignore it
		q = '{8'h05, 8'h00, 8'h11};
		q.push_back(crc8(q) ^ 8'h01);
		send2();
		repeat (20 * B2) @(negedge clk);
		check(n_err2 == 1 && n_req2 == 0 && n_oe2 == 0, "bad check byte");
		q = '{8'h05, 8'hFF, 8'h11};
		q.push_back(crc8(q));
		send2();
		repeat (20 * B2) @(negedge clk);
		check(n_err2 == 1 && n_req2 == 0 && n_oe2 == 0, "reserved address");
		n_addr2 = 8'h00;
		q = '{8'h05, 8'h00, 8'h11};
		q.push_back(crc8(q));
		send2();
		recv2();
		q = '{8'h05, 8'hFF, 8'h11, mem[17][31:24], mem[17][23:16], mem[17][15:8], mem[17][7:0]};
		q.push_back(crc8(q));
		foreach (q[i]) check(r.size() == 8 && r[i] === q[i], "reply byte");
		check(n_req2 == 1 && ra2 === 7'h11 && n_oe2 == 1, "rate-adapted read");
		$display("test second wire done");
		stop_test();
	end

	// watchdog: the full sequence needs about 75000 cycles, so 90000 leaves margin
	initial begin
		repeat (90000) @(posedge clk);
		fail_count++;
		$display("ERROR %0t watchdog expired", $time);
		stop_test();
	end
endmodule : single_wire_uart_read_crc_tb_top
